//--- inc/wrf_map.svh
`ifndef WRF_MAP_SVH
`define WRF_MAP_SVH
// ****************************************************************
// Status word field positions
// ****************************************************************
`define WRF_PSW_X_BIT      4
`define WRF_PSW_M_BIT      5
`define WRF_PSW_WIDTH      11
`define WRF_PSW_RST        11'h000
// ****************************************************************
// Reset values
// ****************************************************************
`define WRF_REG_RST        16'h0000
// ****************************************************************
// Instruction cost for accumulator choice
// ****************************************************************
`define WRF_ACC_A_BYTES    4'h1
`define WRF_ACC_B_BYTES    4'h2
`define WRF_ACC_A_CYCLES   4'h1
`define WRF_ACC_B_CYCLES   4'h2
`endif

//--- inc/wrf_pkg.sv
package wrf_pkg;
    // Register selector
    typedef enum logic [2:0] {
        WRF_SEL_NONE = 3'b000,
        WRF_SEL_A    = 3'b001,
        WRF_SEL_B    = 3'b010,
        WRF_SEL_X    = 3'b011,
        WRF_SEL_Y    = 3'b100,
        WRF_SEL_E    = 3'b101
    } wrf_sel_t;
    // Index use for address generation
    typedef enum logic [1:0] {
        WRF_IDX_NONE = 2'b00,
        WRF_IDX_X    = 2'b01,
        WRF_IDX_Y    = 2'b10
    } wrf_idx_t;
    // Status word update operations
    typedef enum logic [2:0] {
        WRF_PS_HOLD     = 3'b000,
        WRF_PS_SET_M    = 3'b001,
        WRF_PS_CLR_M    = 3'b010,
        WRF_PS_SET_BITS = 3'b011,
        WRF_PS_CLR_BITS = 3'b100
    } wrf_psop_t;
endpackage : wrf_pkg

//--- core/wrf_reg.sv
`include "wrf_map.svh"
module wrf_reg
    import wrf_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Write side
    input  wire logic             we_i,
    input  wire logic             byte_mode_i,
    input  wire logic [WIDTH-1:0] wdata_i,
    // Contents
    output logic      [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] next_q;

    // ****************************************************************
    // Byte mode write keeps the high byte
    // ****************************************************************
    assign next_q = byte_mode_i ? {q_o[WIDTH-1:8], wdata_i[7:0]} : wdata_i; // RULE14

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            q_o <= WIDTH'(`WRF_REG_RST);
        end else if (we_i) begin
            q_o <= next_q;
        end
    end

    property p_keep_high;
        @(posedge clk_i) disable iff (rst_i)
            (we_i && byte_mode_i) |=> q_o[WIDTH-1:8] == $past(q_o[WIDTH-1:8]);
    endproperty
    a_keep_high: assert property (p_keep_high) else $error("high byte changed"); // RULE14
endmodule : wrf_reg

//--- core/wrf_core.sv
// Contract
// RULE1 - Accumulator A sixteen bits, low byte separate
// RULE2 - A width follows data width flag
// RULE3 - Accumulator B matches A behaviour
// RULE4 - B instructions cost more bytes, cycles
// RULE5 - E is B high, A low
// RULE6 - Index X sixteen bits, low byte separate
// RULE7 - Index flag sets both X, Y width
// RULE8 - Index Y sixteen bits, low byte separate
// RULE9 - X indexed address adds X to base
// RULE10 - Y indexed address adds Y to base
// RULE11 - Block and multiply ops point with X
// RULE12 - Block and multiply ops point with Y
// RULE13 - Width flag changed by dedicated, general ops
// RULE14 - Byte writes leave high byte unchanged
`include "wrf_map.svh"
module wrf_core
    import wrf_pkg::*;
#(
    parameter int WIDTH  = 16,
    parameter int AWIDTH = 24
) (
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Register write
    input  wire logic              we_i,
    input  wire wrf_sel_t          wsel_i,
    input  wire logic [2*WIDTH-1:0] wdata_i,
    // Register read
    input  wire wrf_sel_t          rsel_i,
    output logic      [2*WIDTH-1:0] rdata_o,
    // Status word update
    input  wire wrf_psop_t         psop_i,
    input  wire logic [`WRF_PSW_WIDTH-1:0] psmask_i,
    output logic      [`WRF_PSW_WIDTH-1:0] psw_o,
    // Address generation
    input  wire wrf_idx_t          idx_i,
    input  wire logic [AWIDTH-1:0] base_i,
    output logic      [AWIDTH-1:0] ea_o,
    // Table pointers for block move and multiply-accumulate
    input  wire logic              table_op_i,
    output logic      [WIDTH-1:0]  src_ptr_o,
    output logic      [WIDTH-1:0]  dst_ptr_o,
    // Instruction cost of chosen accumulator
    input  wire logic              use_b_i,
    output logic      [3:0]        ins_bytes_o,
    output logic      [3:0]        ins_cycles_o,
    // Width flags
    output logic                   m8_o,
    output logic                   x8_o
);
    // ****************************************************************
    // Status word
    // ****************************************************************
    logic [`WRF_PSW_WIDTH-1:0] psw;
    logic [`WRF_PSW_WIDTH-1:0] next_psw;
    logic [`WRF_PSW_WIDTH-1:0] m_mask;
    logic                      m8;
    logic                      x8;

    assign m_mask = `WRF_PSW_WIDTH'(1) << `WRF_PSW_M_BIT;
    assign m8     = psw[`WRF_PSW_M_BIT];
    assign x8     = psw[`WRF_PSW_X_BIT];

    always_comb begin
        next_psw = psw;
        unique case (psop_i)
            WRF_PS_HOLD:     next_psw = psw;
            WRF_PS_SET_M:    next_psw = psw | m_mask; // RULE13
            WRF_PS_CLR_M:    next_psw = psw & ~m_mask; // RULE13
            WRF_PS_SET_BITS: next_psw = psw | psmask_i; // RULE13
            WRF_PS_CLR_BITS: next_psw = psw & ~psmask_i; // RULE13
            default:         next_psw = psw;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            psw <= `WRF_PSW_RST;
        end else begin
            psw <= next_psw;
        end
    end

    // ****************************************************************
    // Register write decode
    // ****************************************************************
    wire we_a = we_i && (wsel_i == WRF_SEL_A || wsel_i == WRF_SEL_E);
    wire we_b = we_i && (wsel_i == WRF_SEL_B || wsel_i == WRF_SEL_E);
    wire we_x = we_i && (wsel_i == WRF_SEL_X);
    wire we_y = we_i && (wsel_i == WRF_SEL_Y);
    wire e_wr = (wsel_i == WRF_SEL_E);
    wire acc_byte = m8 && !e_wr; // RULE2
    wire [WIDTH-1:0] b_wdata = e_wr ? wdata_i[2*WIDTH-1:WIDTH] : wdata_i[WIDTH-1:0];

    logic [WIDTH-1:0] acc_a;
    logic [WIDTH-1:0] acc_b;
    logic [WIDTH-1:0] idx_x;
    logic [WIDTH-1:0] idx_y;

    // ****************************************************************
    // Registers
    // ****************************************************************
    wrf_reg #(.WIDTH(WIDTH)) u_acc_a ( // RULE1
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .we_i        (we_a),
        .byte_mode_i (acc_byte),
        .wdata_i     (wdata_i[WIDTH-1:0]),
        .q_o         (acc_a)
    );
    wrf_reg #(.WIDTH(WIDTH)) u_acc_b ( // RULE3
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .we_i        (we_b),
        .byte_mode_i (acc_byte),
        .wdata_i     (b_wdata),
        .q_o         (acc_b)
    );
    wrf_reg #(.WIDTH(WIDTH)) u_idx_x ( // RULE6
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .we_i        (we_x),
        .byte_mode_i (x8),
        .wdata_i     (wdata_i[WIDTH-1:0]),
        .q_o         (idx_x)
    );
    wrf_reg #(.WIDTH(WIDTH)) u_idx_y ( // RULE8
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .we_i        (we_y),
        .byte_mode_i (x8),
        .wdata_i     (wdata_i[WIDTH-1:0]),
        .q_o         (idx_y)
    );

    // ****************************************************************
    // Effective widths
    // ****************************************************************
    wire [WIDTH-1:0] a_eff = m8 ? {{(WIDTH-8){1'b0}}, acc_a[7:0]} : acc_a; // RULE2
    wire [WIDTH-1:0] b_eff = m8 ? {{(WIDTH-8){1'b0}}, acc_b[7:0]} : acc_b; // RULE3
    wire [WIDTH-1:0] x_eff = x8 ? {{(WIDTH-8){1'b0}}, idx_x[7:0]} : idx_x; // RULE7
    wire [WIDTH-1:0] y_eff = x8 ? {{(WIDTH-8){1'b0}}, idx_y[7:0]} : idx_y; // RULE7

    // ****************************************************************
    // Read select and address generation
    // ****************************************************************
    logic [2*WIDTH-1:0] rd_sel;
    always_comb begin
        rd_sel = '0;
        unique case (rsel_i)
            WRF_SEL_NONE: rd_sel = '0;
            WRF_SEL_A:    rd_sel = {{WIDTH{1'b0}}, a_eff};
            WRF_SEL_B:    rd_sel = {{WIDTH{1'b0}}, b_eff};
            WRF_SEL_X:    rd_sel = {{WIDTH{1'b0}}, x_eff};
            WRF_SEL_Y:    rd_sel = {{WIDTH{1'b0}}, y_eff};
            WRF_SEL_E:    rd_sel = {acc_b, acc_a}; // RULE5
            default:      rd_sel = '0;
        endcase
    end

    logic [AWIDTH-1:0] ea_sel;
    always_comb begin
        ea_sel = base_i;
        unique case (idx_i)
            WRF_IDX_NONE: ea_sel = base_i;
            WRF_IDX_X:    ea_sel = base_i + AWIDTH'(x_eff); // RULE9
            WRF_IDX_Y:    ea_sel = base_i + AWIDTH'(y_eff); // RULE10
            default:      ea_sel = base_i;
        endcase
    end

    wire [3:0] bytes_sel  = use_b_i ? `WRF_ACC_B_BYTES : `WRF_ACC_A_BYTES; // RULE4
    wire [3:0] cycles_sel = use_b_i ? `WRF_ACC_B_CYCLES : `WRF_ACC_A_CYCLES; // RULE4

    // ****************************************************************
    // Registered outputs
    // ****************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_o      <= '0;
            ea_o         <= '0;
            src_ptr_o    <= '0;
            dst_ptr_o    <= '0;
            ins_bytes_o  <= '0;
            ins_cycles_o <= '0;
            psw_o        <= `WRF_PSW_RST;
            m8_o         <= 1'b0;
            x8_o         <= 1'b0;
        end else begin
            rdata_o      <= rd_sel;
            ea_o         <= ea_sel;
            src_ptr_o    <= table_op_i ? x_eff : src_ptr_o; // RULE11
            dst_ptr_o    <= table_op_i ? y_eff : dst_ptr_o; // RULE12
            ins_bytes_o  <= bytes_sel;
            ins_cycles_o <= cycles_sel;
            psw_o        <= next_psw;
            m8_o         <= next_psw[`WRF_PSW_M_BIT];
            x8_o         <= next_psw[`WRF_PSW_X_BIT];
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    property p_a16;
        @(posedge clk_i) disable iff (rst_i)
            (rsel_i == WRF_SEL_A && !m8) |=> rdata_o == {{WIDTH{1'b0}}, $past(acc_a)};
    endproperty
    a_a16: assert property (p_a16) else $error("A 16-bit read wrong"); // RULE1

    property p_a8;
        @(posedge clk_i) disable iff (rst_i)
            (rsel_i == WRF_SEL_A && m8) |=> rdata_o[2*WIDTH-1:8] == '0;
    endproperty
    a_a8: assert property (p_a8) else $error("A byte read not narrowed"); // RULE2

    property p_b8;
        @(posedge clk_i) disable iff (rst_i)
            (rsel_i == WRF_SEL_B && m8) |=> rdata_o == {{(2*WIDTH-8){1'b0}}, $past(acc_b[7:0])};
    endproperty
    a_b8: assert property (p_b8) else $error("B byte read wrong"); // RULE3

    property p_cost;
        @(posedge clk_i) disable iff (rst_i)
            use_b_i |=> ins_bytes_o > `WRF_ACC_A_BYTES && ins_cycles_o > `WRF_ACC_A_CYCLES;
    endproperty
    a_cost: assert property (p_cost) else $error("B cost not higher"); // RULE4

    property p_e;
        @(posedge clk_i) disable iff (rst_i)
            rsel_i == WRF_SEL_E |=> rdata_o == {$past(acc_b), $past(acc_a)};
    endproperty
    a_e: assert property (p_e) else $error("E view wrong"); // RULE5

    property p_e_wr;
        @(posedge clk_i) disable iff (rst_i)
            (we_i && wsel_i == WRF_SEL_E) |=> {acc_b, acc_a} == $past(wdata_i);
    endproperty
    a_e_wr: assert property (p_e_wr) else $error("E write wrong"); // RULE5

    property p_x16;
        @(posedge clk_i) disable iff (rst_i)
            (rsel_i == WRF_SEL_X && !x8) |=> rdata_o == {{WIDTH{1'b0}}, $past(idx_x)};
    endproperty
    a_x16: assert property (p_x16) else $error("X 16-bit read wrong"); // RULE6

    property p_xy8;
        @(posedge clk_i) disable iff (rst_i)
            (table_op_i && x8) |=> src_ptr_o[WIDTH-1:8] == '0 && dst_ptr_o[WIDTH-1:8] == '0;
    endproperty
    a_xy8: assert property (p_xy8) else $error("index not narrowed"); // RULE7

    property p_x8;
        @(posedge clk_i) disable iff (rst_i)
            (rsel_i == WRF_SEL_X && x8) |=> rdata_o[2*WIDTH-1:8] == '0;
    endproperty
    a_x8: assert property (p_x8) else $error("X byte read not narrowed"); // RULE7

    property p_y8;
        @(posedge clk_i) disable iff (rst_i)
            (rsel_i == WRF_SEL_Y && x8) |=> rdata_o == {{(2*WIDTH-8){1'b0}}, $past(idx_y[7:0])};
    endproperty
    a_y8: assert property (p_y8) else $error("Y byte read wrong"); // RULE8

    property p_eax;
        @(posedge clk_i) disable iff (rst_i)
            idx_i == WRF_IDX_X |=> ea_o == $past(base_i) + AWIDTH'($past(x_eff));
    endproperty
    a_eax: assert property (p_eax) else $error("X indexed address wrong"); // RULE9

    property p_eay;
        @(posedge clk_i) disable iff (rst_i)
            idx_i == WRF_IDX_Y |=> ea_o == $past(base_i) + AWIDTH'($past(y_eff));
    endproperty
    a_eay: assert property (p_eay) else $error("Y indexed address wrong"); // RULE10

    property p_ptr;
        @(posedge clk_i) disable iff (rst_i)
            table_op_i |=> src_ptr_o == $past(x_eff) && dst_ptr_o == $past(y_eff);
    endproperty
    a_ptr: assert property (p_ptr) else $error("table pointers wrong"); // RULE11

    property p_ptr_hold;
        @(posedge clk_i) disable iff (rst_i)
            !table_op_i |=> $stable(src_ptr_o) && $stable(dst_ptr_o);
    endproperty
    a_ptr_hold: assert property (p_ptr_hold) else $error("table pointers moved"); // RULE12

    property p_setm;
        @(posedge clk_i) disable iff (rst_i)
            psop_i == WRF_PS_SET_M |=> m8 && m8_o;
    endproperty
    a_setm: assert property (p_setm) else $error("width flag not set"); // RULE13

    property p_clrm;
        @(posedge clk_i) disable iff (rst_i)
            psop_i == WRF_PS_CLR_M |=> !m8 && !m8_o;
    endproperty
    a_clrm: assert property (p_clrm) else $error("width flag not cleared by op"); // RULE13

    property p_clrbits;
        @(posedge clk_i) disable iff (rst_i)
            (psop_i == WRF_PS_CLR_BITS && psmask_i[`WRF_PSW_M_BIT]) |=> !m8;
    endproperty
    a_clrbits: assert property (p_clrbits) else $error("width flag not cleared"); // RULE13
endmodule : wrf_core

//--- sim/wrf_core_tb_top.sv
`include "wrf_map.svh"
module wrf_core_tb_top
    import wrf_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************************************
    // Signals and instance
    // ****************************************************************
    logic        clk_i, rst_i, we_i, table_op_i, use_b_i;
    wrf_sel_t    wsel_i, rsel_i;
    wrf_psop_t   psop_i;
    wrf_idx_t    idx_i;
    logic [31:0] wdata_i, rdata_o;
    logic [10:0] psmask_i, psw_o;
    logic [23:0] base_i, ea_o;
    logic [15:0] src_ptr_o, dst_ptr_o;
    logic [3:0]  ins_bytes_o, ins_cycles_o;
    logic        m8_o, x8_o;
    int          bad_count, check_count;

    wrf_core dut_u (.clk_i(clk_i), .rst_i(rst_i), .we_i(we_i), .wsel_i(wsel_i),
        .wdata_i(wdata_i), .rsel_i(rsel_i), .rdata_o(rdata_o), .psop_i(psop_i),
        .psmask_i(psmask_i), .psw_o(psw_o), .idx_i(idx_i), .base_i(base_i), .ea_o(ea_o),
        .table_op_i(table_op_i), .src_ptr_o(src_ptr_o), .dst_ptr_o(dst_ptr_o),
        .use_b_i(use_b_i), .ins_bytes_o(ins_bytes_o), .ins_cycles_o(ins_cycles_o),
        .m8_o(m8_o), .x8_o(x8_o));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic finish_test();
        if (bad_count == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test

    task automatic cmp(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : cmp

    task automatic wr(input wrf_sel_t sel, input logic [31:0] d);
        @(posedge clk_i);
        we_i    <= 1'b1;
        wsel_i  <= sel;
        wdata_i <= d;
        @(posedge clk_i);
        we_i    <= 1'b0;
        wsel_i  <= WRF_SEL_NONE;
    endtask : wr

    task automatic rd(input wrf_sel_t sel, input logic [31:0] exp);
        @(posedge clk_i);
        rsel_i <= sel;
        @(posedge clk_i);
        #1;
        cmp(sel.name(), exp, rdata_o);
    endtask : rd

    task automatic ps(input wrf_psop_t op, input logic [10:0] mk, input logic m, input logic x);
        @(posedge clk_i);
        psop_i   <= op;
        psmask_i <= mk;
        @(posedge clk_i);
        psop_i   <= WRF_PS_HOLD;
        #1;
        cmp("m8", {31'h0, m}, {31'h0, m8_o});
        cmp("x8", {31'h0, x}, {31'h0, x8_o});
    endtask : ps

    task automatic ea(input wrf_idx_t i, input logic [23:0] b, input logic [23:0] exp);
        @(posedge clk_i);
        idx_i  <= i;
        base_i <= b;
        @(posedge clk_i);
        #1;
        cmp("ea", {8'h00, exp}, {8'h00, ea_o});
    endtask : ea

    task automatic tbl(input logic [15:0] s, input logic [15:0] d);
        @(posedge clk_i);
        table_op_i <= 1'b1;
        @(posedge clk_i);
        table_op_i <= 1'b0;
        #1;
        cmp("src", {16'h0, s}, {16'h0, src_ptr_o});
        cmp("dst", {16'h0, d}, {16'h0, dst_ptr_o});
    endtask : tbl
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset();
        @(posedge clk_i);
        #1;
        cmp("rdata", 32'h0, rdata_o);
        cmp("psw", 32'h0, {21'h0, psw_o});
        cmp("ea", 32'h0, {8'h00, ea_o});
        cmp("flags", 32'h0, {30'h0, m8_o, x8_o});
    endtask : t_reset

    task automatic t_full();
        wr(WRF_SEL_A, 32'h0000_1234);
        wr(WRF_SEL_B, 32'h0000_5678);
        wr(WRF_SEL_X, 32'h0000_9abc);
        wr(WRF_SEL_Y, 32'h0000_def0);
        rd(WRF_SEL_A, 32'h0000_1234);
        rd(WRF_SEL_B, 32'h0000_5678);
        rd(WRF_SEL_X, 32'h0000_9abc);
        rd(WRF_SEL_Y, 32'h0000_def0);
        rd(WRF_SEL_E, 32'h5678_1234);
        wr(WRF_SEL_E, 32'h89ab_cdef);
        rd(WRF_SEL_A, 32'h0000_cdef);
        rd(WRF_SEL_B, 32'h0000_89ab);
    endtask : t_full

    task automatic t_acc_byte();
        ps(WRF_PS_SET_M, 11'h000, 1'b1, 1'b0);
        cmp("psw", 32'h20, {21'h0, psw_o});
        wr(WRF_SEL_A, 32'h0011_2255);
        rd(WRF_SEL_A, 32'h0000_0055);
        wr(WRF_SEL_B, 32'h0000_4466);
        rd(WRF_SEL_B, 32'h0000_0066);
        rd(WRF_SEL_E, 32'h8966_cd55);
        wr(WRF_SEL_X, 32'h0000_1357);
        rd(WRF_SEL_X, 32'h0000_1357);
        ps(WRF_PS_CLR_M, 11'h000, 1'b0, 1'b0);
        rd(WRF_SEL_A, 32'h0000_cd55);
        ps(WRF_PS_SET_BITS, 11'h020, 1'b1, 1'b0);
        ps(WRF_PS_CLR_BITS, 11'h020, 1'b0, 1'b0);
    endtask : t_acc_byte

    task automatic t_idx_byte();
        ps(WRF_PS_SET_BITS, 11'h010, 1'b0, 1'b1);
        wr(WRF_SEL_X, 32'h0000_aa77);
        rd(WRF_SEL_X, 32'h0000_0077);
        rd(WRF_SEL_Y, 32'h0000_00f0);
        wr(WRF_SEL_Y, 32'h0000_0011);
        rd(WRF_SEL_Y, 32'h0000_0011);
        rd(WRF_SEL_A, 32'h0000_cd55);
        ea(WRF_IDX_X, 24'h100000, 24'h100077);
        ea(WRF_IDX_Y, 24'h100000, 24'h100011);
        tbl(16'h0077, 16'h0011);
        ps(WRF_PS_CLR_BITS, 11'h010, 1'b0, 1'b0);
        rd(WRF_SEL_X, 32'h0000_1377);
        ea(WRF_IDX_X, 24'h00fff0, 24'h011367);
        ea(WRF_IDX_Y, 24'h00fff0, 24'h01de01);
        tbl(16'h1377, 16'hde11);
        wr(WRF_SEL_X, 32'h0000_0000);
        @(posedge clk_i);
        #1;
        cmp("src", 32'h1377, {16'h0, src_ptr_o});
    endtask : t_idx_byte

    task automatic t_cost();
        @(posedge clk_i);
        use_b_i <= 1'b1;
        @(posedge clk_i);
        #1;
        cmp("bytes_b", {28'h0, `WRF_ACC_B_BYTES}, {28'h0, ins_bytes_o});
        cmp("cycles_b", {28'h0, `WRF_ACC_B_CYCLES}, {28'h0, ins_cycles_o});
        @(posedge clk_i);
        use_b_i <= 1'b0;
        @(posedge clk_i);
        #1;
        cmp("bytes_a", {28'h0, `WRF_ACC_A_BYTES}, {28'h0, ins_bytes_o});
        cmp("cycles_a", {28'h0, `WRF_ACC_A_CYCLES}, {28'h0, ins_cycles_o});
    endtask : t_cost
    // ****************************************************************
    // Clock, reset, sequence
    // ****************************************************************
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    initial begin
        #150000;
        bad_count++;
        finish_test();
    end

    initial begin
        rst_i = 1'b1; we_i = 1'b0; wsel_i = WRF_SEL_NONE; wdata_i = 32'h0;
        rsel_i = WRF_SEL_NONE; psop_i = WRF_PS_HOLD; psmask_i = 11'h000;
        idx_i = WRF_IDX_NONE; base_i = 24'h0; table_op_i = 1'b0; use_b_i = 1'b0;
        bad_count = 0;
        check_count = 0;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_full();
        t_acc_byte();
        t_idx_byte();
        t_cost();
        finish_test();
    end
endmodule : wrf_core_tb_top
